//--- inc/phy_mgmt_defs.svh
`ifndef PHY_MGMT_DEFS_SVH
`define PHY_MGMT_DEFS_SVH
// ------------------------------------------------------------
// Register indices
// ------------------------------------------------------------
`define IDX_BASIC_MODE_CONTROL   5'h00
`define IDX_BASIC_MODE_STATUS    5'h01
`define IDX_PHY_IDENT_HIGH       5'h02
`define IDX_PHY_IDENT_LOW        5'h03
`define IDX_AN_ADVERTISE         5'h04
`define IDX_AN_PARTNER_ABILITY   5'h05
`define IDX_AN_EXPANSION         5'h06
// ------------------------------------------------------------
// Control field positions
// ------------------------------------------------------------
`define CTL_SOFT_RESET   15
`define CTL_LOOPBACK     14
`define CTL_SPEED        13
`define CTL_AN_ENABLE    12
`define CTL_POWER_DOWN   11
`define CTL_AN_RESTART   9
`define CTL_DUPLEX       8
`define CTL_COL_TEST     7
// ------------------------------------------------------------
// Status fixed bits, advertisement and expansion fields
// ------------------------------------------------------------
`define STS_FIXED_MASK   16'hFFC9
`define STS_FIXED_VALUE  16'h7809
`define ADV_PAUSE        10
`define ADV_ABIL_HI      8
`define ADV_ABIL_LO      5
`define ADV_SEL_HI       4
`define ADV_SEL_LO       0
`define LP_VALID_MASK    16'hE7FF
`define STS_AN_DONE      5
`define STS_REMOTE_FAULT 4
`define STS_LINK         2
`define STS_JABBER       1
`define EXP_PAR_FAULT    4
`define EXP_LP_NEXT      3
`define EXP_NEW_PAGE     1
`define EXP_LP_AN        0
`define LP_NEXT_PAGE     15
`define ADV_WR_MASK      16'h05FF
// ------------------------------------------------------------
// Reset values and timing
// ------------------------------------------------------------
`define RST_SPEED        1'b1
`define RST_AN_ENABLE    1'b1
`define RST_DUPLEX       1'b1
`define RST_ADV_ABIL     4'hF
`define RST_ADV_SEL      5'h01
`define SOFT_RST_CYCLES  5'h10
`endif

//--- inc/phy_mgmt_pkg.sv
package phy_mgmt_pkg;
  typedef enum logic [1:0] {
    ACC_IDLE = 2'h0,
    ACC_EXEC = 2'h1,
    ACC_DONE = 2'h3
  } acc_state_e;

  typedef struct packed {
    logic        write;
    logic [4:0]  index;
    logic [15:0] wdata;
  } acc_req_s;

  typedef struct packed {
    logic        an_done;
    logic        an_speed_100;
    logic        an_full_duplex;
    logic        remote_fault;
    logic        link_ok;
    logic        jabber;
    logic        page_valid;
    logic [15:0] partner_page;
    logic        parallel_detect_fault;
    logic        partner_an_able;
  } phy_events_s;

  typedef struct packed {
    acc_state_e  st;
    acc_req_s    req;
    logic [15:0] rdata;
    logic        soft_rst;
    logic [4:0]  rst_cnt;
    logic        loopback;
    logic        speed;
    logic        an_en;
    logic        pwr_dn;
    logic        an_rst;
    logic        duplex;
    logic        col_test;
    logic        pause;
    logic [3:0]  adv;
    logic [4:0]  sel;
    logic [15:0] lp;
    logic        rf;
    logic        link;
    logic        jab;
    logic        pdf;
    logic        npr;
    logic        an_prev;
  } bank_state_s;
endpackage

//--- design/phy_mgmt_register_bank.sv
// Summary of operation
// R01: Writing control bit 15 starts soft reset; it self-clears when done.
// R02: Control bit 14 enables loopback; resets to zero.
// R03: Control bit 13 picks 100Mb/s when one, 10Mb/s when zero.
// R04: Control bit 12 enables negotiation; manual speed and duplex then ignored.
// R05: Control bit 11 powers the PHY down; resets to zero.
// R06: Writing control bit 9 restarts negotiation; clears when negotiation ends.
// R07: Control bit 8 selects full duplex when negotiation is off.
// R08: Control bit 7 enables collision test; bit 10 reads zero.
// R09: Status capability bits are fixed constants.
// R10: Status bit 5 shows negotiation complete.
// R11: Status bit 4 latches far-end fault; status read clears it.
// R12: Status bit 2 is latch-low link status, resets to zero.
// R13: Status bit 1 latches jabber; resets to zero.
// R14: First identifier holds vendor bits 3 to 18 on bits 15 to 0.
// R15: Second identifier holds vendor bits 19 to 24, model and revision.
// R16: Advertisement bits 8 to 5 are writable ability enables, reset one.
// R17: Selector 4:0 writable, resets to 00001; bits 15 and 9 read zero.
// R18: Pause advertisement bit 10 is writable, reset zero, no PHY effect.
// R19: Partner ability is read-only, resets zero, mirrors partner base page.
// R20: Expansion bits 4 and 1 latch high; bit 2 reads zero.
// R21: Expansion bit 3 partner next page, bit 0 partner negotiation.
// R22: Access takes index, write flag, data; done ends it, read data returns.
// R23: Latch-high bits hold until read; latch-low holds zero until read.
`timescale 1ns/1ns
`default_nettype none
`include "phy_mgmt_defs.svh"

module phy_mgmt_register_bank #(
  parameter logic [24:1] VENDOR_OUI = 24'h5A3C96, // Arbitrary value.
  parameter logic [5:0]  MODEL_NUM  = 6'h2A,      // Arbitrary value.
  parameter logic [3:0]  REV_NUM    = 4'h5        // Arbitrary value.
) (
  input  wire logic                     CLK_I,
  input  wire logic                     RST_I,
  input  wire logic                     ACC_VALID_I,
  input  wire phy_mgmt_pkg::acc_req_s   ACC_REQ_I,
  input  wire phy_mgmt_pkg::phy_events_s EV_I,
  output logic                          ACC_BUSY_O,
  output logic                          ACC_DONE_O,
  output logic [15:0]                   ACC_RDATA_O,
  output logic                          PHY_RESET_O,
  output logic                          LOOPBACK_O,
  output logic                          SPEED_100_O,
  output logic                          FULL_DUPLEX_O,
  output logic                          AN_ENABLE_O,
  output logic                          AN_RESTART_O,
  output logic                          POWER_DOWN_O,
  output logic                          COLLISION_TEST_O,
  output logic [15:0]                   ADVERTISE_O
);
  import phy_mgmt_pkg::*;

  bank_state_s s;
  bank_state_s next_s;
  logic [21:0] id_bits;
  logic [15:0] ctl_word;
  logic [15:0] sts_word;
  logic [15:0] adv_word;
  logic [15:0] exp_word;
  logic [15:0] rd_word;
  logic        exec;
  logic        done_edge;

  // ----------------------------------------------------------
  // Identifier wiring
  // ----------------------------------------------------------
  // Vendor bits are laid in reverse order; the bottom two are dropped.
  genvar gi;
  generate
    for (gi = 0; gi < 22; gi++) begin : g_oui
      assign id_bits[21-gi] = VENDOR_OUI[3+gi]; // R14 R15
    end
  endgenerate

  // ----------------------------------------------------------
  // Read view of each register
  // ----------------------------------------------------------
  // Reserved fields read as zero so software sees a stable value.
  always_comb begin
    ctl_word = 16'h0000;
    ctl_word[`CTL_SOFT_RESET] = s.soft_rst;
    ctl_word[`CTL_LOOPBACK]   = s.loopback;
    ctl_word[`CTL_SPEED]      = s.speed;
    ctl_word[`CTL_AN_ENABLE]  = s.an_en;
    ctl_word[`CTL_POWER_DOWN] = s.pwr_dn;
    ctl_word[`CTL_AN_RESTART] = s.an_rst;
    ctl_word[`CTL_DUPLEX]     = s.duplex;
    ctl_word[`CTL_COL_TEST]   = s.col_test; // R08
    sts_word = `STS_FIXED_VALUE; // R09
    sts_word[`STS_AN_DONE]      = EV_I.an_done; // R10
    sts_word[`STS_REMOTE_FAULT] = s.rf;
    sts_word[`STS_LINK]         = s.link;
    sts_word[`STS_JABBER]       = s.jab;
    adv_word = 16'h0000; // R17
    adv_word[`ADV_PAUSE] = s.pause;
    adv_word[`ADV_ABIL_HI:`ADV_ABIL_LO] = s.adv;
    adv_word[`ADV_SEL_HI:`ADV_SEL_LO]   = s.sel;
    exp_word = 16'h0000; // R21
    exp_word[`EXP_PAR_FAULT] = s.pdf;
    exp_word[`EXP_LP_NEXT]   = s.lp[`LP_NEXT_PAGE]; // R21
    exp_word[`EXP_NEW_PAGE]  = s.npr;
    exp_word[`EXP_LP_AN]     = EV_I.partner_an_able; // R21
    case (s.req.index)
      `IDX_BASIC_MODE_CONTROL: rd_word = ctl_word;
      `IDX_BASIC_MODE_STATUS:  rd_word = sts_word;
      `IDX_PHY_IDENT_HIGH:     rd_word = id_bits[21:6]; // R14
      `IDX_PHY_IDENT_LOW:      rd_word = {id_bits[5:0], MODEL_NUM,
                                          REV_NUM}; // R15
      `IDX_AN_ADVERTISE:       rd_word = adv_word;
      `IDX_AN_PARTNER_ABILITY: rd_word = s.lp; // R19
      `IDX_AN_EXPANSION:       rd_word = exp_word;
      default:                 rd_word = 16'h0000;
    endcase
  end

  // ----------------------------------------------------------
  // Next state
  // ----------------------------------------------------------
  // Defaults for every bank field, keeping the access machine and an_prev.
  function automatic bank_state_s dflt(input bank_state_s c);
    bank_state_s d;
    d = '0;
    d.st       = c.st;
    d.req      = c.req;
    d.rdata    = c.rdata;
    d.speed    = `RST_SPEED;
    d.an_en    = `RST_AN_ENABLE;
    d.duplex   = `RST_DUPLEX;
    d.adv      = `RST_ADV_ABIL; // R16
    d.sel      = `RST_ADV_SEL; // R17
    d.an_prev  = c.an_prev;
    return d;
  endfunction

  assign exec      = (s.st == ACC_EXEC);
  assign done_edge = EV_I.an_done && !s.an_prev;

  // Clear-on-read is applied first so a read in the same cycle as an
  // event still leaves the event recorded afterwards.
  always_comb begin
    next_s = s;
    next_s.an_prev = EV_I.an_done;
    // Clear-on-read for the status and expansion latches.
    if (exec && !s.req.write &&
        s.req.index == `IDX_BASIC_MODE_STATUS) begin
      next_s.rf   = 1'b0; // R23
      next_s.jab  = 1'b0;
      next_s.link = EV_I.link_ok; // R23
    end else begin
      next_s.link = s.link & EV_I.link_ok; // R12
    end
    if (exec && !s.req.write &&
        s.req.index == `IDX_AN_EXPANSION) begin
      next_s.pdf = 1'b0;
      next_s.npr = 1'b0;
    end
    if (EV_I.remote_fault) next_s.rf = 1'b1; // R11
    if (EV_I.jabber) next_s.jab = 1'b1; // R13
    if (EV_I.parallel_detect_fault) next_s.pdf = 1'b1; // R20
    if (EV_I.page_valid) begin
      next_s.npr = 1'b1; // R20
      next_s.lp  = EV_I.partner_page & `LP_VALID_MASK; // R19
    end
    // Restart bit drops when negotiation finishes.
    if (s.an_rst && done_edge) next_s.an_rst = 1'b0; // R06
    // Register writes; ignored while a soft reset runs.
    if (exec && s.req.write && !s.soft_rst) begin
      if (s.req.index == `IDX_BASIC_MODE_CONTROL) begin
        if (s.req.wdata[`CTL_SOFT_RESET]) begin
          next_s          = dflt(next_s); // R01
          next_s.soft_rst = 1'b1;
          next_s.rst_cnt  = `SOFT_RST_CYCLES;
        end else begin
          next_s.loopback = s.req.wdata[`CTL_LOOPBACK]; // R02
          next_s.speed    = s.req.wdata[`CTL_SPEED]; // R03
          next_s.an_en    = s.req.wdata[`CTL_AN_ENABLE]; // R04
          next_s.pwr_dn   = s.req.wdata[`CTL_POWER_DOWN]; // R05
          next_s.duplex   = s.req.wdata[`CTL_DUPLEX]; // R07
          next_s.col_test = s.req.wdata[`CTL_COL_TEST]; // R08
          if (s.req.wdata[`CTL_AN_RESTART]) begin
            next_s.an_rst = 1'b1; // R06
          end
        end
      end else if (s.req.index == `IDX_AN_ADVERTISE) begin
        next_s.pause = s.req.wdata[`ADV_PAUSE]; // R18
        next_s.adv = s.req.wdata[`ADV_ABIL_HI:`ADV_ABIL_LO]; // R16
        next_s.sel = s.req.wdata[`ADV_SEL_HI:`ADV_SEL_LO]; // R17
      end
    end
    // Soft reset counts down, then returns every field except the access machine and an_prev to default.
    if (s.soft_rst) begin
      next_s.rst_cnt = s.rst_cnt - 5'h01;
      if (s.rst_cnt == 5'h01) begin
        next_s = dflt(next_s); // R01
        next_s.an_prev = EV_I.an_done;
      end
    end
    // Access sequencer: take, execute, answer for one cycle.
    case (s.st)
      ACC_IDLE: begin
        if (ACC_VALID_I) begin
          next_s.st  = ACC_EXEC; // R22
          next_s.req = ACC_REQ_I;
        end
      end
      ACC_EXEC: begin
        next_s.st = ACC_DONE;
        if (!s.req.write) next_s.rdata = rd_word; // R22
      end
      ACC_DONE: next_s.st = ACC_IDLE;
      default:  next_s.st = ACC_IDLE;
    endcase
  end

  // ----------------------------------------------------------
  // State register
  // ----------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      s <= dflt('0);
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------
  // Negotiated mode overrides the manual bits while enabled.
  assign SPEED_100_O   = s.an_en ? EV_I.an_speed_100 : s.speed; // R04
  assign FULL_DUPLEX_O = s.an_en ? EV_I.an_full_duplex
                                 : s.duplex; // R07
  assign ACC_BUSY_O       = (s.st != ACC_IDLE); // R22
  assign ACC_DONE_O       = (s.st == ACC_DONE);
  assign ACC_RDATA_O      = s.rdata;
  assign PHY_RESET_O      = s.soft_rst;
  assign LOOPBACK_O       = s.loopback;
  assign AN_ENABLE_O      = s.an_en;
  assign AN_RESTART_O     = s.an_rst;
  assign POWER_DOWN_O     = s.pwr_dn;
  assign COLLISION_TEST_O = s.col_test;
  assign ADVERTISE_O      = adv_word;

  // ----------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  sequence s_take;
    ACC_VALID_I && !ACC_BUSY_O;
  endsequence
  sequence s_answer;
    ##2 ACC_DONE_O ##1 !ACC_BUSY_O;
  endsequence

  property p_access_done;
    s_take |-> s_answer;
  endproperty
  a_access_done: assert property (p_access_done) // R22
    else $error("Access did not finish in three cycles.");

  property p_soft_reset;
    $rose(s.soft_rst) |-> s.soft_rst[*8] ##1 s.soft_rst[*8] ##1 !s.soft_rst;
  endproperty
  a_soft_reset: assert property (p_soft_reset) // R01
    else $error("Soft reset did not self-clear on time.");

  property p_loopback;
    exec && s.req.write && !s.soft_rst &&
    s.req.index == `IDX_BASIC_MODE_CONTROL &&
    !s.req.wdata[`CTL_SOFT_RESET]
    |=> LOOPBACK_O == $past(s.req.wdata[`CTL_LOOPBACK]);
  endproperty
  a_loopback: assert property (p_loopback) // R02
    else $error("Loopback output does not follow the write.");

  property p_manual_mode;
    !AN_ENABLE_O |-> SPEED_100_O == ctl_word[`CTL_SPEED] &&
                     FULL_DUPLEX_O == ctl_word[`CTL_DUPLEX];
  endproperty
  a_manual_mode: assert property (p_manual_mode) // R03
    else $error("Manual speed or duplex not applied.");

  property p_auto_mode;
    AN_ENABLE_O |-> SPEED_100_O == EV_I.an_speed_100 &&
                    FULL_DUPLEX_O == EV_I.an_full_duplex;
  endproperty
  a_auto_mode: assert property (p_auto_mode) // R04
    else $error("Manual bits not ignored under negotiation.");

  property p_restart_clear;
    AN_RESTART_O && done_edge && !exec && !s.soft_rst
    |=> !AN_RESTART_O;
  endproperty
  a_restart_clear: assert property (p_restart_clear) // R06
    else $error("Restart bit stayed set after negotiation.");

  property p_status_fixed;
    ACC_DONE_O && !s.req.write &&
    s.req.index == `IDX_BASIC_MODE_STATUS
    |-> (ACC_RDATA_O & `STS_FIXED_MASK) == `STS_FIXED_VALUE;
  endproperty
  a_status_fixed: assert property (p_status_fixed) // R09
    else $error("Status constant bits read wrong.");

  property p_remote_fault;
    EV_I.remote_fault |=> s.rf ##1 (s.rf || $past(exec));
  endproperty
  a_remote_fault: assert property (p_remote_fault) // R11
    else $error("Remote fault was not latched.");

  property p_link_low;
    !EV_I.link_ok |=> !s.link;
  endproperty
  a_link_low: assert property (p_link_low) // R12
    else $error("Link loss was not latched low.");

  property p_jabber;
    EV_I.jabber |=> s.jab;
  endproperty
  a_jabber: assert property (p_jabber) // R13
    else $error("Jabber was not latched.");

  property p_ident;
    ACC_DONE_O && !s.req.write &&
    s.req.index == `IDX_PHY_IDENT_HIGH
    |-> ACC_RDATA_O == id_bits[21:6];
  endproperty
  a_ident: assert property (p_ident) // R14
    else $error("Identifier read returned wrong bits.");

  // Control writes that are not a soft reset land on the next edge.
  sequence s_ctl_write;
    exec && s.req.write && !s.soft_rst &&
    s.req.index == `IDX_BASIC_MODE_CONTROL &&
    !s.req.wdata[`CTL_SOFT_RESET];
  endsequence

  property p_power_down;
    s_ctl_write |=> POWER_DOWN_O == $past(s.req.wdata[`CTL_POWER_DOWN]);
  endproperty
  a_power_down: assert property (p_power_down) // R05
    else $error("Power-down output does not follow the write.");

  property p_col_test;
    s_ctl_write |=> COLLISION_TEST_O == $past(s.req.wdata[`CTL_COL_TEST]);
  endproperty
  a_col_test: assert property (p_col_test) // R08
    else $error("Collision test output does not follow the write.");

  property p_adv_write;
    exec && s.req.write && !s.soft_rst &&
    s.req.index == `IDX_AN_ADVERTISE
    |=> ADVERTISE_O == ($past(s.req.wdata) & `ADV_WR_MASK);
  endproperty
  a_adv_write: assert property (p_adv_write) // R16 R17 R18
    else $error("Advertisement write not applied as masked.");

  property p_soft_block;
    s.soft_rst && exec && s.req.write |=> $stable(ADVERTISE_O);
  endproperty
  a_soft_block: assert property (p_soft_block) // R01
    else $error("A write landed while soft reset was running.");

  property p_status_clear;
    exec && !s.req.write &&
    s.req.index == `IDX_BASIC_MODE_STATUS &&
    !EV_I.remote_fault |=> !s.rf;
  endproperty
  a_status_clear: assert property (p_status_clear) // R11 R23
    else $error("Status read did not clear the fault latch.");

  property p_new_page;
    EV_I.page_valid && !exec && !s.soft_rst
    |=> exp_word[`EXP_NEW_PAGE] &&
        s.lp == ($past(EV_I.partner_page) & `LP_VALID_MASK);
  endproperty
  a_new_page: assert property (p_new_page) // R19 R20
    else $error("Received page was not stored and flagged.");

  property p_done_pulse;
    ACC_DONE_O |=> !ACC_DONE_O;
  endproperty
  a_done_pulse: assert property (p_done_pulse) // R22
    else $error("Done stood for more than one cycle.");
endmodule // phy_mgmt_register_bank
`default_nettype wire

//--- test/mgmt_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// Host-side indirect management access model
// ------------------------------------------------------------
module mgmt_host_model (
  input  wire logic                   clk_i,
  input  wire logic                   busy_i,
  input  wire logic                   done_i,
  output var  logic                   valid_o,
  output var  phy_mgmt_pkg::acc_req_s req_o
);
  import phy_mgmt_pkg::*;

  // The request lines start quiet before the first access.
  initial begin
    valid_o = 1'b0;
    req_o   = '0;
  end

  // One access: wait for idle, present the whole request for one take edge,
  // then poll the done pulse under a bound so a dead port cannot hang us.
  task automatic access(input logic wr, input logic [4:0] idx,
                        input logic [15:0] wd, output logic hung);
    int n;
    n = 0;
    @(negedge clk_i);
    while (busy_i !== 1'b0 && n < 16) begin
      @(negedge clk_i);
      n++;
    end
    valid_o <= 1'b1;
    req_o   <= '{write: wr, index: idx, wdata: wd};
    @(posedge clk_i);
    @(negedge clk_i);
    valid_o <= 1'b0;
    // Released lines are scrambled so no stale value looks valid.
    req_o   <= acc_req_s'(~req_o);
    n = 0;
    while (done_i !== 1'b1 && n < 16) begin
      @(negedge clk_i);
      n++;
    end
    hung = (n >= 16);
  endtask
endmodule // mgmt_host_model
`default_nettype wire

//--- test/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// Register bank testbench
// ------------------------------------------------------------
module tb_top;
  import phy_mgmt_pkg::*;

  localparam logic [24:1] P_OUI   = 24'hC3A51E; // Arbitrary value.
  localparam logic [5:0]  P_MODEL = 6'h15;      // Arbitrary value.
  localparam logic [3:0]  P_REV   = 4'hA;       // Arbitrary value.

  typedef struct packed {
    logic        chk;
    logic [15:0] val;
  } note_s;

  logic        clk;
  logic        rst;
  logic        valid;
  logic        busy;
  logic        done;
  logic        phy_rst;
  logic        loopback;
  logic        spd;
  logic        fdx;
  logic        an_en;
  logic        an_rs;
  logic        pwr;
  logic        col;
  logic        hung;
  logic [15:0] rdata;
  logic [15:0] adv;
  logic [15:0] page;
  logic [15:0] v;
  acc_req_s    req;
  phy_events_s ev;
  note_s       exp_q[$];
  note_s       cur;
  int          mismatches;
  int          tests_run;
  int          seed;
  int          n;

  // Free-running 100 MHz clock.
  initial clk = 1'b0;
  always #5 clk = ~clk;

  phy_mgmt_register_bank #(
    .VENDOR_OUI(P_OUI), .MODEL_NUM(P_MODEL), .REV_NUM(P_REV)
  ) phy_mgmt_register_bank_inst (
    .CLK_I(clk), .RST_I(rst), .ACC_VALID_I(valid), .ACC_REQ_I(req),
    .EV_I(ev), .ACC_BUSY_O(busy), .ACC_DONE_O(done), .ACC_RDATA_O(rdata),
    .PHY_RESET_O(phy_rst), .LOOPBACK_O(loopback), .SPEED_100_O(spd),
    .FULL_DUPLEX_O(fdx), .AN_ENABLE_O(an_en), .AN_RESTART_O(an_rs),
    .POWER_DOWN_O(pwr), .COLLISION_TEST_O(col), .ADVERTISE_O(adv)
  );

  mgmt_host_model mgmt_host_model_inst (
    .clk_i(clk), .busy_i(busy), .done_i(done), .valid_o(valid), .req_o(req)
  );

  // ----------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------
  task automatic print_verdict();
    if (mismatches == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t output %h expected %h", $time, got, exp);
    end
  endtask

  // Each access leaves a note; writes carry nothing to compare.
  task automatic acc(input logic w, input logic [4:0] i,
                     input logic [15:0] d, input logic [15:0] e);
    exp_q.push_back('{chk: ~w, val: e});
    mgmt_host_model_inst.access(w, i, d, hung);
    if (hung) begin
      mismatches++;
      $display("ERROR %0t access never completed", $time);
    end
  endtask

  task automatic wr(input logic [4:0] i, input logic [15:0] d);
    acc(1'b1, i, d, 16'h0000);
  endtask

  task automatic rd(input logic [4:0] i, input logic [15:0] e);
    acc(1'b0, i, 16'h0000, e);
  endtask

  // Vendor code bits land reversed: the lowest kept bit sits on bit 15.
  function automatic logic [15:0] id_hi();
    logic [15:0] r;
    for (int k = 0; k < 16; k++) r[15-k] = P_OUI[3+k];
    return r;
  endfunction

  function automatic logic [15:0] id_lo();
    logic [15:0] r;
    for (int k = 0; k < 6; k++) r[15-k] = P_OUI[19+k];
    r[9:0] = {P_MODEL, P_REV};
    return r;
  endfunction

  // The monitor takes the oldest note whenever a done pulse shows.
  always @(negedge clk) begin
    if (done === 1'b1) begin
      if (exp_q.size() == 0) begin
        mismatches++;
        $display("ERROR %0t done without a request", $time);
      end else begin
        cur = exp_q.pop_front();
        if (cur.chk) tests_run++;
        if (cur.chk && rdata !== cur.val) begin
          mismatches++;
          $display("ERROR %0t read %h expected %h", $time, rdata, cur.val);
        end
      end
    end
  end

  // A hang is cut short well after the sequence should have ended.
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    $display("ERROR %0t watchdog expired", $time);
    print_verdict();
  end

  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    seed = 35245;
    mismatches = 0;
    tests_run = 0;
    rst = 1'b1;
    ev = '0;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    rd(5'h00, 16'h3100);
    rd(5'h01, 16'h7809);
    rd(5'h02, id_hi());
    rd(5'h03, id_lo());
    rd(5'h04, 16'h01E1);
    rd(5'h05, 16'h0000);
    rd(5'h06, 16'h0000);
    // Manual mode must ignore the negotiated result.
    ev.an_speed_100 = 1'b1;
    ev.an_full_duplex = 1'b1;
    wr(5'h00, 16'h4CFF);
    rd(5'h00, 16'h4880);
    chk(loopback, 16'h0001);
    chk(spd, 16'h0000);
    chk(fdx, 16'h0000);
    chk(pwr, 16'h0001);
    chk(col, 16'h0001);
    chk(an_en, 16'h0000);
    ev.an_speed_100 = 1'b0;
    ev.an_full_duplex = 1'b1;
    wr(5'h00, 16'h3100);
    chk(spd, 16'h0000);
    chk(fdx, 16'h0001);
    chk(an_en, 16'h0001);
    // The negotiated result must reach the outputs as it changes.
    ev.an_speed_100 = 1'b1;
    @(negedge clk);
    chk(spd, 16'h0001);
    // Restart holds until negotiation completes.
    wr(5'h00, 16'h3300);
    repeat (4) @(negedge clk);
    chk(an_rs, 16'h0001);
    rd(5'h00, 16'h3300);
    ev.an_done = 1'b1;
    repeat (3) @(negedge clk);
    chk(an_rs, 16'h0000);
    rd(5'h00, 16'h3100);
    rd(5'h01, 16'h7829);
    // Latching status bits.
    ev.link_ok = 1'b1;
    ev.remote_fault = 1'b1;
    ev.jabber = 1'b1;
    @(negedge clk);
    ev.remote_fault = 1'b0;
    ev.jabber = 1'b0;
    rd(5'h01, 16'h783B);
    rd(5'h01, 16'h782D);
    ev.link_ok = 1'b0;
    @(negedge clk);
    ev.link_ok = 1'b1;
    rd(5'h01, 16'h7829);
    rd(5'h01, 16'h782D);
    // Partner pages and expansion latches.
    for (int k = 0; k < 2; k++) begin
      page = 16'($random(seed));
      ev.partner_page = page;
      ev.partner_an_able = k[0];
      ev.page_valid = 1'b1;
      ev.parallel_detect_fault = 1'b1;
      @(negedge clk);
      ev.page_valid = 1'b0;
      ev.parallel_detect_fault = 1'b0;
      rd(5'h05, page & 16'hE7FF);
      rd(5'h06, {11'h000, 1'b1, page[15], 2'b01, k[0]});
      rd(5'h06, {12'h000, page[15], 2'b00, k[0]});
    end
    v = 16'($random(seed));
    wr(5'h04, v);
    rd(5'h04, v & 16'h05FF);
    chk(adv, v & 16'h05FF);
    // Read-only and unmapped places ignore writes.
    for (int j = 1; j < 8; j++) begin
      if (j != 4) wr(5'(j), 16'hFFFF);
    end
    wr(5'h1F, 16'hFFFF);
    rd(5'h01, 16'h782D);
    rd(5'h02, id_hi());
    rd(5'h03, id_lo());
    rd(5'h05, page & 16'hE7FF);
    rd(5'h06, {12'h000, page[15], 3'b001});
    rd(5'h07, 16'h0000);
    rd(5'h1F, 16'h0000);
    // Soft reset restores defaults and blocks writes meanwhile.
    wr(5'h00, 16'h8000);
    chk(phy_rst, 16'h0001);
    rd(5'h00, 16'hB100);
    wr(5'h04, 16'h0000);
    n = 0;
    while (phy_rst !== 1'b0 && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk(phy_rst, 16'h0000);
    rd(5'h00, 16'h3100);
    rd(5'h04, 16'h01E1);
    repeat (5) @(negedge clk);
    if (exp_q.size() != 0) begin
      mismatches++;
      $display("ERROR %0t results missing", $time);
    end
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
